// file: rtl/rms_pkg.sv
// shared constants and types for the reset and mode select logic
package rms_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ         = 25_000_000;
   localparam int SELF_HZ        = 8_000_000;
   localparam int RST_SELF_TICKS = 34;
   localparam int SELF_DIV       = CLK_HZ / SELF_HZ;
   localparam int RST_CYC        = (RST_SELF_TICKS * CLK_HZ + SELF_HZ - 1) / SELF_HZ;
   localparam int BIT_TICKS      = 16;
   localparam int SPEEDUP_TICKS  = 1;
   localparam int FLT_LEN        = 2;

   // ---------------------------------------------------------------
   // reset cause field layout
   // ---------------------------------------------------------------
   localparam int CAUSE_W    = 8;
   localparam int CAUSE_POR  = 7;
   localparam int CAUSE_PIN  = 6;
   localparam int CAUSE_WDOG = 5;
   localparam int CAUSE_ILOP = 4;
   localparam int CAUSE_ILAD = 3;
   localparam int CAUSE_LVD  = 1;
   localparam int CAUSE_DBG  = 2;
   localparam logic [CAUSE_W-1:0] CAUSE_RST = 8'h80;

   typedef enum logic { RMS_MODE_NORMAL, RMS_MODE_BACKGROUND } rms_mode_t;

   typedef struct packed {
      logic por;
      logic pin;
      logic wdog;
      logic ilop;
      logic ilad;
      logic dbg;
      logic lvd;
   } rms_src_t;

   typedef struct packed {
      logic bandHigh;
      logic selfClkStop;
   } rms_clkcfg_t;

   typedef struct packed {
      logic o;
      logic oe;
   } rms_drv_t;
endpackage

// file: rtl/rms_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none
module rms_sync (
   // clock
   input  wire logic clock,
   // pin side
   input  wire logic pinIn,
   // synced level
   output logic      pinOut
);
   logic meta_q;

   always_ff @(posedge clock) begin
      meta_q <= pinIn;
      pinOut <= meta_q;
   end
endmodule
`default_nettype wire

// file: rtl/rms_tick_div.sv
// divider giving one-cycle enable pulses at a programmable ratio
`timescale 1ns/100ps
`default_nettype none
module rms_tick_div (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       srst,
   // control
   input  wire logic       run,
   input  wire logic [7:0] divRatio,
   // output enable pulse
   output logic            tick
);
   logic [7:0] cnt_q;

   always_ff @(posedge clock) begin
      if (srst || !run) begin
         cnt_q <= 8'h00;
         tick  <= 1'b0;
      end else if (cnt_q + 8'h01 >= divRatio) begin
         cnt_q <= 8'h00;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         tick  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: rtl/rms_reset_mode.sv
// reset pin sequencing, reset cause capture and boot mode selection
`timescale 1ns/100ps
`default_nettype none
// Operation
// - any reset drives the reset pin low for about 34 self-clock periods
// - the cause of each reset sets its flag in the cause register
// - mode pin low at reset release starts active background debug mode
// - mode pin left high at reset release starts normal mode
// - shared pin is mode input in reset, debug wire right after release
// - in mode-select function the shared pin never enables its driver
// - each debug bit lasts 16 debug controller clocks
// - debug clock may run up to bus rate; bit timing scales with it
// - debug pin is pseudo open-drain with brief driven-high speedup pulses
// - reset startup runs from the internal self-clock of about 8 MHz
// - software may choose the self-clock for recovery from stop
// - one band bit in clock control 1 picks the crystal range
module rms_reset_mode (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          srst,
   // internal reset sources
   input  wire rms_pkg::rms_src_t             srcReq,
   // reset pin
   input  wire logic                          resetPinIn,
   output logic                               resetPinOut,
   output logic                               resetPinOe,
   // debug mode pin
   input  wire logic                          debugModePinIn,
   output logic                               debugModePinOut,
   output logic                               debugModePinOe,
   // debug controller link
   input  wire logic                          dbgClkSel,
   input  wire logic                          dbgTxValid,
   input  wire logic                          dbgTxBit,
   output logic                               dbgTxReady,
   output logic                               dbgRxValid,
   output logic                               dbgRxBit,
   // clock generator control
   input  wire logic                          clkCfgWrite,
   input  wire rms_pkg::rms_clkcfg_t          clkCfgData,
   input  wire logic                          stopExit,
   output rms_pkg::rms_clkcfg_t               clkCfg,
   output logic                               useSelfClock,
   // status
   output logic [rms_pkg::CAUSE_W-1:0]        resetCause,
   output rms_pkg::rms_mode_t                 bootMode,
   output logic                               systemReset
);
   typedef enum logic [1:0] { ST_POR, ST_DRIVE, ST_WAIT_HIGH, ST_RUN } rms_state_t;
   typedef enum logic [1:0] { TX_IDLE, TX_LOW, TX_SPEEDUP, TX_RELEASE } rms_tx_t;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic resetPinSync;
   logic modePinSync;

   rms_sync uResetSync (
      .clock  (clock),
      .pinIn  (resetPinIn),
      .pinOut (resetPinSync)
   );

   rms_sync uModeSync (
      .clock  (clock),
      .pinIn  (debugModePinIn),
      .pinOut (modePinSync)
   );

   // ---------------------------------------------------------------
   // reset sequencer
   // ---------------------------------------------------------------
   rms_state_t                     state_q;
   logic [15:0]                    rstCnt_q;
   logic [rms_pkg::CAUSE_W-1:0]    cause_q;
   logic [rms_pkg::CAUSE_W-1:0]    causeHit;
   logic                           anySrc;
   logic                           pinLow;
   logic                           pinLowPrev_q;

   function automatic logic [rms_pkg::CAUSE_W-1:0] causeOf(input rms_pkg::rms_src_t s, input logic p);
      logic [rms_pkg::CAUSE_W-1:0] v;
      v = '0;
      v[rms_pkg::CAUSE_POR]  = s.por;
      v[rms_pkg::CAUSE_PIN]  = p | s.pin;
      v[rms_pkg::CAUSE_WDOG] = s.wdog;
      v[rms_pkg::CAUSE_ILOP] = s.ilop;
      v[rms_pkg::CAUSE_ILAD] = s.ilad;
      v[rms_pkg::CAUSE_DBG]  = s.dbg;
      v[rms_pkg::CAUSE_LVD]  = s.lvd;
      return v;
   endfunction

   // external pull-low seen only when we are not driving ourselves
   assign pinLow   = !resetPinSync && (state_q == ST_RUN);
   assign causeHit = causeOf(srcReq, pinLow);
   assign anySrc   = |causeHit;

   always_ff @(posedge clock) begin
      if (srst) begin
         state_q  <= ST_POR;
         rstCnt_q <= 16'h0000;
      end else begin
         unique case (state_q)
            ST_POR: begin
               // por cycle already drives the pin, so it is the first low cycle
               state_q  <= ST_DRIVE;
               rstCnt_q <= 16'(rms_pkg::RST_CYC - 1);
            end
            ST_DRIVE: begin
               if (rstCnt_q == 16'h0001) begin
                  state_q <= ST_WAIT_HIGH;
               end
               rstCnt_q <= rstCnt_q - 16'h0001;
            end
            ST_WAIT_HIGH: begin
               if (resetPinSync) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (anySrc) begin
                  state_q  <= ST_DRIVE;
                  rstCnt_q <= 16'(rms_pkg::RST_CYC);
               end
            end
         endcase
      end
   end

   // cause register: newest reset replaces older flags
   always_ff @(posedge clock) begin
      if (srst) begin
         cause_q <= rms_pkg::CAUSE_RST;
      end else if (state_q == ST_RUN && anySrc) begin
         cause_q <= causeHit;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pinLowPrev_q <= 1'b0;
      end else begin
         pinLowPrev_q <= pinLow;
      end
   end

   logic inReset;
   assign inReset     = (state_q != ST_RUN);
   assign resetPinOut = 1'b0;
   assign resetPinOe  = (state_q == ST_DRIVE) || (state_q == ST_POR);
   assign systemReset = inReset;
   assign resetCause  = cause_q;

   // ---------------------------------------------------------------
   // mode latch at reset release
   // ---------------------------------------------------------------
   rms_pkg::rms_mode_t mode_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         mode_q <= rms_pkg::RMS_MODE_NORMAL;
      end else if (state_q == ST_WAIT_HIGH && resetPinSync) begin
         // sample once on the release edge, hold until next reset
         mode_q <= modePinSync ? rms_pkg::RMS_MODE_NORMAL : rms_pkg::RMS_MODE_BACKGROUND;
      end
   end
   assign bootMode = mode_q;

   // ---------------------------------------------------------------
   // clock generator control
   // ---------------------------------------------------------------
   rms_pkg::rms_clkcfg_t clkCfg_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         clkCfg_q <= '0;
      end else if (clkCfgWrite) begin
         clkCfg_q <= clkCfgData;
      end
   end
   assign clkCfg       = clkCfg_q;
   assign useSelfClock = inReset || (stopExit && clkCfg_q.selfClkStop);

   // ---------------------------------------------------------------
   // debug wire bit engine
   // ---------------------------------------------------------------
   logic    dbgTick;
   logic [7:0] dbgRatio;
   rms_tx_t tx_q;
   logic [4:0] txCnt_q;
   logic    txBit_q;
   logic    rxBit_q;
   logic    rxValid_q;

   // bus-rate debug clock or self-clock tick, bit time scales with it
   assign dbgRatio = dbgClkSel ? 8'(rms_pkg::SELF_DIV) : 8'h01;

   rms_tick_div uDbgDiv (
      .clock    (clock),
      .srst     (srst),
      .run      (!inReset),
      .divRatio (dbgRatio),
      .tick     (dbgTick)
   );

   always_ff @(posedge clock) begin
      if (srst || inReset) begin
         tx_q      <= TX_IDLE;
         txCnt_q   <= 5'h00;
         txBit_q   <= 1'b0;
         rxBit_q   <= 1'b0;
         rxValid_q <= 1'b0;
      end else begin
         rxValid_q <= 1'b0;
         unique case (tx_q)
            TX_IDLE: begin
               if (dbgTxValid) begin
                  tx_q    <= TX_LOW;
                  txBit_q <= dbgTxBit;
                  txCnt_q <= 5'h00;
               end
            end
            TX_LOW: begin
               if (dbgTick) begin
                  txCnt_q <= txCnt_q + 5'h01;
                  if (txCnt_q == 5'(rms_pkg::BIT_TICKS / 4 - 1)) begin
                     tx_q <= txBit_q ? TX_SPEEDUP : TX_RELEASE;
                  end
               end
            end
            TX_SPEEDUP: begin
               if (dbgTick) begin
                  tx_q    <= TX_RELEASE;
                  txCnt_q <= txCnt_q + 5'h01;
               end
            end
            TX_RELEASE: begin
               if (dbgTick) begin
                  txCnt_q <= txCnt_q + 5'h01;
                  if (txCnt_q == 5'(rms_pkg::BIT_TICKS / 2)) begin
                     rxBit_q <= modePinSync;
                  end
                  if (txCnt_q == 5'(rms_pkg::BIT_TICKS - 1)) begin
                     tx_q      <= TX_IDLE;
                     rxValid_q <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   assign dbgTxReady      = !inReset && (tx_q == TX_IDLE);
   assign dbgRxValid      = rxValid_q;
   assign dbgRxBit        = rxBit_q;
   assign debugModePinOut = (tx_q == TX_SPEEDUP);
   // driver off whole time in reset: pin is mode input only
   assign debugModePinOe  = !inReset && (tx_q == TX_LOW || tx_q == TX_SPEEDUP);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   logic [15:0] lowRun_q;
   always_ff @(posedge clock) begin
      if (srst || !resetPinOe) begin
         lowRun_q <= 16'h0000;
      end else begin
         lowRun_q <= lowRun_q + 16'h0001;
      end
   end

   reset_pulse_len_a: assert property (@(posedge clock) disable iff (srst)
      $fell(resetPinOe) |-> lowRun_q == 16'(rms_pkg::RST_CYC))
      else $error("reset pulse length wrong");

   cause_on_reset_a: assert property (@(posedge clock) disable iff (srst)
      (state_q == ST_RUN && anySrc) |=> (resetCause == $past(causeHit) && resetPinOe))
      else $error("cause not recorded");

   mode_bg_a: assert property (@(posedge clock) disable iff (srst)
      (state_q == ST_WAIT_HIGH && resetPinSync && !modePinSync) |=> bootMode == rms_pkg::RMS_MODE_BACKGROUND)
      else $error("background mode not entered");

   mode_normal_a: assert property (@(posedge clock) disable iff (srst)
      (state_q == ST_WAIT_HIGH && resetPinSync && modePinSync) |=> bootMode == rms_pkg::RMS_MODE_NORMAL)
      else $error("normal mode not entered");

   mode_pin_input_a: assert property (@(posedge clock) disable iff (srst)
      systemReset |-> !debugModePinOe)
      else $error("mode pin driven in reset");

   mode_hold_a: assert property (@(posedge clock) disable iff (srst)
      (!systemReset && $past(!systemReset)) |-> $stable(bootMode))
      else $error("mode changed outside release");

   bit_time_a: assert property (@(posedge clock) disable iff (srst || systemReset)
      (tx_q == TX_IDLE && dbgTxValid && !dbgClkSel) ##1 (!dbgClkSel)[*8] |-> tx_q != TX_IDLE)
      else $error("bit ended early");

   speedup_high_a: assert property (@(posedge clock) disable iff (srst)
      (debugModePinOe && debugModePinOut) |-> tx_q == TX_SPEEDUP && txBit_q)
      else $error("speedup pulse misplaced");

   self_clk_a: assert property (@(posedge clock) disable iff (srst)
      resetPinOe |-> useSelfClock)
      else $error("startup not on self clock");

   pin_reset_a: assert property (@(posedge clock) disable iff (srst)
      (pinLow && !pinLowPrev_q) |=> (resetPinOe && resetCause[rms_pkg::CAUSE_PIN]))
      else $error("pin reset not taken");
endmodule
`default_nettype wire

// file: verif/rms_pod_model.sv
// debug pod and reset switch model with pin level resolution
`timescale 1ns/100ps
`default_nettype none
module rms_pod_model (
   // clock
   input  wire logic       clock,
   // device pin drivers
   input  wire logic       resetPinOut,
   input  wire logic       resetPinOe,
   input  wire logic       debugModePinOut,
   input  wire logic       debugModePinOe,
   // scenario control
   input  wire logic       pressSwitch,
   input  wire logic       holdModeLow,
   input  wire logic       answerLow,
   input  wire logic [7:0] answerLen,
   // resolved pin levels
   output logic            resetWire,
   output logic            debugWire
);
   int   modeHold = 0;
   int   ansCnt   = 0;
   logic dbgPrev  = 1'b1;
   // both pins pulled up; a switch to ground forces reset
   assign resetWire = !(pressSwitch || (resetPinOe && !resetPinOut));
   assign debugWire = debugModePinOe ? debugModePinOut : !(modeHold > 0 || ansCnt > 0);
   always @(posedge clock) begin
      // mode pin held low through reset and a little past its rise
      if (!resetWire && holdModeLow) modeHold <= 8;
      else if (modeHold > 0) modeHold <= modeHold - 1;
      // low answer stretched past mid-bit, released inside the bit time
      if (answerLow && dbgPrev && !debugWire) ansCnt <= int'(answerLen);
      else if (ansCnt > 0) ansCnt <= ansCnt - 1;
      dbgPrev <= debugWire;
   end
endmodule
`default_nettype wire

// file: verif/tb_rms_reset_mode.sv
// self-checking bench for the reset and mode select logic
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_rms_reset_mode;
   // 34 self-clock periods of 125 ns, in 40 ns cycles rounded up
   localparam int EXP_LOW = (34 * 125 + 39) / 40;
   logic                        clock = 1'b0, srst = 1'b1, dbgClkSel = 1'b0, dbgTxValid = 1'b0;
   logic                        dbgTxBit = 1'b0, clkCfgWrite = 1'b0, stopExit = 1'b0;
   rms_pkg::rms_src_t           srcReq = '0;
   rms_pkg::rms_clkcfg_t        clkCfgData = '0, clkCfg;
   logic                        resetPinOut, resetPinOe, debugModePinOut, debugModePinOe;
   logic                        dbgTxReady, dbgRxValid, dbgRxBit, useSelfClock, systemReset;
   logic [rms_pkg::CAUSE_W-1:0] resetCause;
   rms_pkg::rms_mode_t          bootMode;
   logic                        pressSwitch = 1'b0, holdModeLow = 1'b0, answerLow = 1'b0;
   logic [7:0]                  answerLen = 8'h00;
   logic                        resetWire, debugWire;
   int                          mismatches = 0, checks_done = 0, cycles = 0, seed = 20;
   int causePos [8] = '{rms_pkg::CAUSE_LVD, rms_pkg::CAUSE_DBG, rms_pkg::CAUSE_ILAD, rms_pkg::CAUSE_ILOP,
                        rms_pkg::CAUSE_WDOG, rms_pkg::CAUSE_PIN, rms_pkg::CAUSE_POR, rms_pkg::CAUSE_PIN};

   rms_reset_mode u_rms_reset_mode (.clock(clock), .srst(srst), .srcReq(srcReq), .resetPinIn(resetWire),
      .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .debugModePinIn(debugWire),
      .debugModePinOut(debugModePinOut), .debugModePinOe(debugModePinOe), .dbgClkSel(dbgClkSel),
      .dbgTxValid(dbgTxValid), .dbgTxBit(dbgTxBit), .dbgTxReady(dbgTxReady), .dbgRxValid(dbgRxValid),
      .dbgRxBit(dbgRxBit), .clkCfgWrite(clkCfgWrite), .clkCfgData(clkCfgData), .stopExit(stopExit),
      .clkCfg(clkCfg), .useSelfClock(useSelfClock), .resetCause(resetCause), .bootMode(bootMode),
      .systemReset(systemReset));

   rms_pod_model u_rms_pod_model (.clock(clock), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
      .debugModePinOut(debugModePinOut), .debugModePinOe(debugModePinOe), .pressSwitch(pressSwitch),
      .holdModeLow(holdModeLow), .answerLow(answerLow), .answerLen(answerLen),
      .resetWire(resetWire), .debugWire(debugWire));

   initial begin
      forever #20 clock = ~clock;
   end

   // ------------------------------------------------------------
   // watchdog and shared-pin monitor
   // ------------------------------------------------------------
   always @(posedge clock) begin
      cycles++;
      if (systemReset === 1'b1) `CHK(debugModePinOe, 1'b0)
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic waitRun();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (systemReset !== 1'b0 && n < 400);
      `CHK(systemReset, 1'b0)
      `CHK(dbgTxReady, 1'b1)
   endtask

   // source 0..6 pulses an internal request, 7 presses the switch
   task automatic trigReset(input int idx, input rms_pkg::rms_mode_t expMode);
      int n, m;
      n = 0;
      m = 0;
      @(posedge clock);
      if (idx < 7) srcReq[idx] <= 1'b1;
      else pressSwitch <= 1'b1;
      while (m < 300 && !(n > 0 && resetPinOe !== 1'b1)) begin
         @(posedge clock);
         m++;
         srcReq <= (m == 30) ? 7'h10 : 7'h00;
         if (m == 10) pressSwitch <= 1'b0;
         if (m == 20) begin
            `CHK(dbgTxReady, 1'b0)
            `CHK(useSelfClock, 1'b1)
            `CHK(resetPinOut, 1'b0)
         end
         if (resetPinOe === 1'b1) n++;
      end
      `CHK(n, EXP_LOW)
      waitRun();
      `CHK(resetCause, 8'h01 << causePos[idx])
      `CHK(bootMode, expMode)
   endtask

   task automatic dbgBit(input logic sel, input logic b, input logic hold);
      int div, n, lo, hi;
      div = sel ? rms_pkg::SELF_DIV : 1;
      n = 0;
      lo = 0;
      hi = 0;
      @(posedge clock);
      dbgClkSel <= sel;
      answerLow <= hold & !b;
      answerLen <= 8'(11 * div);
      @(posedge clock);
      dbgTxValid <= 1'b1;
      dbgTxBit <= b;
      do @(posedge clock); while (dbgTxReady !== 1'b1 && ++n < 50);
      dbgTxValid <= 1'b0;
      n = 0;
      while (n < 100) begin
         @(posedge clock);
         n++;
         if (debugModePinOe === 1'b1 && debugModePinOut === 1'b0) lo++;
         if (debugModePinOe === 1'b1 && debugModePinOut === 1'b1) hi++;
         if (dbgRxValid === 1'b1) break;
      end
      `CHK(dbgRxBit, !(hold && !b))
      `CHK(n >= 15 * div + 2 && n <= 16 * div + 1, 1'b1)
      `CHK(hi, b ? div : 0)
      `CHK(lo >= 3 * div && lo <= 5 * div, 1'b1)
      answerLow <= 1'b0;
      @(posedge clock);
   endtask

   task automatic cfgStep();
      logic [1:0] c;
      logic       s;
      c = 2'($random(seed));
      s = 1'($random(seed));
      @(posedge clock);
      clkCfgWrite <= 1'b1;
      clkCfgData <= c;
      stopExit <= s;
      @(posedge clock);
      clkCfgWrite <= 1'b0;
      @(posedge clock);
      `CHK(clkCfg, c)
      `CHK(useSelfClock, s & c[0])
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      `CHK(clkCfg, 2'h0)
      `CHK(resetCause, rms_pkg::CAUSE_RST)
      `CHK(useSelfClock, 1'b1)
      srst <= 1'b0;
      waitRun();
      `CHK(bootMode, rms_pkg::RMS_MODE_NORMAL)
      for (int i = 0; i < 8; i++) trigReset(i, rms_pkg::RMS_MODE_NORMAL);
      holdModeLow <= 1'b1;
      trigReset(6, rms_pkg::RMS_MODE_BACKGROUND);
      holdModeLow <= 1'b0;
      repeat (12) @(posedge clock);
      for (int i = 0; i < 12; i++) dbgBit(i[0], 1'($random(seed)), 1'($random(seed)));
      `CHK(bootMode, rms_pkg::RMS_MODE_BACKGROUND)
      trigReset(1, rms_pkg::RMS_MODE_NORMAL);
      for (int i = 0; i < 8; i++) dbgBit(i[1], 1'($random(seed)), 1'($random(seed)));
      repeat (4) cfgStep();
      srst <= 1'b1;
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      waitRun();
      `CHK(resetCause, rms_pkg::CAUSE_RST)
      `CHK(clkCfg, 2'h0)
      end_of_test();
   end
endmodule
`default_nettype wire
